/* File: include/cps_pkg.sv */
// Purpose: constants for the condition-present status block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: bits 14:0 below the documented fields read as zero in present and status; mask bits 14:0 are writable
package cps_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] CPS_OFF_PRESENT = 8'h20;
   localparam logic [7:0] CPS_OFF_STATUS = 8'h24;
   localparam logic [7:0] CPS_OFF_MASK = 8'h28;
   // field positions in the present word
   localparam int CPS_ACK_LO = 28;
   localparam int CPS_SOC_BIT = 27;
   localparam int CPS_UCLK_BIT = 26;
   localparam int CPS_FCLK_BIT = 25;
   localparam int CPS_HEC_BIT = 24;
   localparam int CPS_RXMEM_BIT = 23;
   localparam int CPS_TXMEM_BIT = 22;
   localparam int CPS_ALMEM_BIT = 21;
   localparam int CPS_CHMEM_BIT = 20;
   localparam int CPS_HPAR_LO = 16;
   localparam int CPS_BP_BIT = 15;
   // reset values
   localparam logic [31:0] CPS_RST_WORD = 32'h0000_0000;
   localparam logic [31:0] CPS_RST_MASK = 32'h0000_0000;
   // header parity covers this many nibbles
   localparam int CPS_HDR_NIBBLES = 12;
endpackage : cps_pkg

/* File: rtl/cps_status.sv */
// Purpose: condition-present status word with sticky events and interrupt
// Assumes: detector inputs are pulses or levels from other clock domains
// Notes: every detector input passes two flip-flops before use
//
// Decided for this implementation: register access over Wishbone.

////////////////////////////////////////////////////////////////////////////////
module cps_status #(
   parameter int PORTS = 4
) (
   input wire logic mclk, // core clock, 40 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic [31:0] wb_adr_i, // byte address
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic wb_we_i, // write enable
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   output logic irq, // level interrupt
   input wire logic [PORTS-1:0] missing_acknowledge_flags, // per-port no ack seen
   input wire logic cell_if_start_fault, // start-of-cell fault
   input wire logic cell_if_clock_fault, // cell-interface clock fault
   input wire logic fabric_clock_fault, // fabric clock fault
   input wire logic receive_header_check_fault, // last header check bad
   input wire logic receive_memory_parity_fault, // last rx memory parity bad
   input wire logic transmit_memory_parity_fault, // last tx memory parity bad
   input wire logic address_list_parity_fault, // last address list parity bad
   input wire logic channel_memory_parity_fault, // last channel memory parity bad
   input wire logic [PORTS-1:0] header_parity_fault, // per-port header parity bad
   input wire logic backpressure_violation_flag // cell against backpressure
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [31:0] sync1;
      logic [31:0] sync2;
      logic [31:0] present;
      logic [31:0] status;
      logic [31:0] mask;
      logic [31:0] rdata;
      logic ack;
      logic irq;
   } cps_state_t;

   cps_state_t st_q;
   cps_state_t st_d;
   logic [31:0] raw;
   logic hit;

   // bytewise merge of write data
   function automatic logic [31:0] cps_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : cps_merge

   ////////////////////////////////////////////////////////////////////////////
   // gather detector levels into word layout
   always_comb begin
      raw = cps_pkg::CPS_RST_WORD;
      raw[cps_pkg::CPS_ACK_LO +: 4] = missing_acknowledge_flags[3:0];
      raw[cps_pkg::CPS_SOC_BIT] = cell_if_start_fault;
      raw[cps_pkg::CPS_UCLK_BIT] = cell_if_clock_fault;
      raw[cps_pkg::CPS_FCLK_BIT] = fabric_clock_fault;
      raw[cps_pkg::CPS_HEC_BIT] = receive_header_check_fault;
      raw[cps_pkg::CPS_RXMEM_BIT] = receive_memory_parity_fault;
      raw[cps_pkg::CPS_TXMEM_BIT] = transmit_memory_parity_fault;
      raw[cps_pkg::CPS_ALMEM_BIT] = address_list_parity_fault;
      raw[cps_pkg::CPS_CHMEM_BIT] = channel_memory_parity_fault;
      raw[cps_pkg::CPS_HPAR_LO +: 4] = header_parity_fault[3:0];
      raw[cps_pkg::CPS_BP_BIT] = backpressure_violation_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state: sync, present, sticky, bus
   always_comb begin
      st_d = st_q;
      hit = wb_cyc_i & wb_stb_i & ~st_q.ack;
      st_d.sync1 = raw;
      st_d.sync2 = st_q.sync1;
      // present word follows detectors every clock
      st_d.present = st_q.sync2;
      // sticky events: rising condition sets, write one clears, set wins
      st_d.status = st_q.status;
      if (hit && wb_we_i && wb_adr_i[7:0] == cps_pkg::CPS_OFF_STATUS) begin
         st_d.status = st_q.status & ~cps_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
      end
      st_d.status = st_d.status | (st_q.sync2 & ~st_q.present);
      if (hit && wb_we_i && wb_adr_i[7:0] == cps_pkg::CPS_OFF_MASK) begin
         st_d.mask = cps_merge(st_q.mask, wb_dat_i, wb_sel_i);
      end
      // writes to present word dropped
      st_d.ack = hit;
      st_d.rdata = 32'h0000_0000;
      if (hit && !wb_we_i) begin
         unique case (wb_adr_i[7:0])
            cps_pkg::CPS_OFF_PRESENT: st_d.rdata = st_q.present;
            cps_pkg::CPS_OFF_STATUS: st_d.rdata = st_q.status;
            cps_pkg::CPS_OFF_MASK: st_d.rdata = st_q.mask;
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
      st_d.irq = |(st_d.status & st_d.mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q.sync1 <= cps_pkg::CPS_RST_WORD;
         st_q.sync2 <= cps_pkg::CPS_RST_WORD;
         st_q.present <= cps_pkg::CPS_RST_WORD;
         st_q.status <= cps_pkg::CPS_RST_WORD;
         st_q.mask <= cps_pkg::CPS_RST_MASK;
         st_q.rdata <= 32'h0000_0000;
         st_q.ack <= 1'b0;
         st_q.irq <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flops
   assign wb_dat_o = st_q.rdata;
   assign wb_ack_o = st_q.ack;
   assign irq = st_q.irq;

endmodule : cps_status

/* File: verif/cps_status_properties.sv */
// Purpose: bus and present-word checks for cps_status
// Assumes: bound to every port of cps_status
// Notes: det gathers the detector levels in word order
module cps_status_properties #(parameter int PORTS = 4) (
   input wire logic mclk, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq,
   input wire logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic [PORTS-1:0] missing_acknowledge_flags, header_parity_fault,
   input wire logic cell_if_start_fault, cell_if_clock_fault, fabric_clock_fault,
   input wire logic receive_header_check_fault, receive_memory_parity_fault,
   input wire logic transmit_memory_parity_fault, address_list_parity_fault,
   input wire logic channel_memory_parity_fault, backpressure_violation_flag
);
   logic [16:0] det;
   logic req;
   // detector levels and a fresh request
   assign det = {missing_acknowledge_flags[3:0], cell_if_start_fault, cell_if_clock_fault,
      fabric_clock_fault, receive_header_check_fault, receive_memory_parity_fault,
      transmit_memory_parity_fault, address_list_parity_fault, channel_memory_parity_fault,
      header_parity_fault[3:0], backpressure_violation_flag};
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_settled;
      $stable(det)[*5];
   endsequence
   sequence s_read_present;
      req && !wb_we_i && wb_adr_i == 32'h0000_0020;
   endsequence
   a_pres_follow: assert property (s_settled ##0 s_read_present |=>
      wb_dat_o[31:15] == $past(det)) else $error("present word differs from detectors");
   a_low_zero: assert property (wb_ack_o && $past(wb_adr_i) == 32'h20 |->
      wb_dat_o[14:0] == 15'h0) else $error("present low bits not zero");
   a_reset_quiet: assert property ($rose(rst_n) |->
      !wb_ack_o && !irq && wb_dat_o == 32'h0) else $error("outputs busy after reset");
   a_ack_latency: assert property (req |=> wb_ack_o) else $error("ack not one cycle late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
   a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[7:0] > 8'h2B |=>
      wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule : cps_status_properties
bind cps_status cps_status_properties #(.PORTS(PORTS)) u_props (.*);

/* File: verif/tb_top.sv */
// Purpose: register-level test of the condition-present status block
// Assumes: one wishbone cycle at a time
// Notes: cond holds detector levels at their present-word positions
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, cond, q;
   logic [3:0] wb_sel_i;
   int miscompares, tests_run;
   cps_status u_cps_status (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
      .missing_acknowledge_flags(cond[31:28]), .cell_if_start_fault(cond[27]),
      .cell_if_clock_fault(cond[26]), .fabric_clock_fault(cond[25]),
      .receive_header_check_fault(cond[24]), .receive_memory_parity_fault(cond[23]),
      .transmit_memory_parity_fault(cond[22]), .address_list_parity_fault(cond[21]),
      .channel_memory_parity_fault(cond[20]), .header_parity_fault(cond[19:16]),
      .backpressure_violation_flag(cond[15]));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // one classic cycle, held until ack
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      if (wb_ack_o !== 1'b1) miscompares++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(q, e, nm);
   endtask : rd
   task automatic give_verdict();
      if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      {rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, cond} = '0;
      wb_sel_i = 4'hF;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(32'h20, 32'h0, "present");
      rd(32'h28, 32'h0, "mask");
      // walk one detector at a time across the word
      for (int i = 15; i < 32; i++) begin
         cond <= 32'h1 << i;
         repeat (6) @(posedge mclk);
         rd(32'h20, 32'h1 << i, "present");
      end
      chk({31'h0, irq}, 32'h0, "irq masked");
      cond <= 32'h0;
      repeat (6) @(posedge mclk);
      rd(32'h20, 32'h0, "present");
      rd(32'h24, 32'hFFFF_8000, "status");
      bus(1'b1, 32'h20, 32'hFFFF_FFFF);
      rd(32'h20, 32'h0, "present");
      bus(1'b1, 32'h28, 32'h0800_0000);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h1, "irq");
      bus(1'b1, 32'h24, 32'h0800_0000);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0, "irq");
      rd(32'h24, 32'hF7FF_8000, "status");
      rd(32'h28, 32'h0800_0000, "mask");
      rd(32'h40, 32'h0, "unmapped");
      give_verdict();
   end
   // cut a hang short
   initial begin
      #100us;
      miscompares++;
      give_verdict();
   end
endmodule : tb_top
